/* hdl/gom_consts.vh */
`ifndef GOM_CONSTS_VH
`define GOM_CONSTS_VH
// ------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ------------------------------------------------------------
`define GOM_OFS_CHAR 5'h00
`define GOM_OFS_ENABLES 5'h04
`define GOM_OFS_XADDR 5'h08
`define GOM_OFS_BASE 5'h0C
`define GOM_OFS_STATUS 5'h10
// ------------------------------------------------------------
// AXI response codes
// ------------------------------------------------------------
`define GOM_RESP_OKAY 2'h0
`define GOM_RESP_SLVERR 2'h2
// ------------------------------------------------------------
// Command letters and character classes
// ------------------------------------------------------------
`define GOM_CMD_NOP 7'h40
`define GOM_CMD_REG0 7'h41
`define GOM_CMD_GRAPH0 7'h42
`define GOM_CMD_MARK0 7'h43
`define GOM_CMD_HLINE 7'h44
`define GOM_CMD_XLOAD 7'h48
`define GOM_CMD_REG1 7'h49
`define GOM_CMD_GRAPH1 7'h4A
`define GOM_CMD_MARK1 7'h4B
`define GOM_CMD_VLINE 7'h4C
`define GOM_CLASS_CMD 2'h2
`define GOM_CLASS_DATA 2'h1
// ------------------------------------------------------------
// Field bit positions
// ------------------------------------------------------------
`define GOM_R0A_DISPLAY 0
`define GOM_R0A_GRAPH0 1
`define GOM_R0A_GRAPH1 2
`define GOM_R0A_HIST0 3
`define GOM_R0A_HIST1 4
`define GOM_R0B_BASESEL 0
`define GOM_R0B_BASE0 1
`define GOM_R0B_BASE1 2
`define GOM_R0B_SINGLE 3
`define GOM_R0B_DUAL 4
`define GOM_R1A_HLINE 0
`define GOM_R1A_VLINE 1
`define GOM_R1A_MARK0 2
`define GOM_R1A_MARK1 3
`define GOM_R1B_SQUARE 0
`define GOM_WBIT 4
// ------------------------------------------------------------
// Reset values and raster figures
// ------------------------------------------------------------
`define GOM_RST_REG5 5'h00
`define GOM_Y_RECT 8'd230
`define GOM_Y_SQUARE 8'd240
`define GOM_CLK_NS 10
`define GOM_DOT_NS_RECT 96
`define GOM_DOT_NS_SQUARE 80
`define GOM_MARGIN_NS_RECT 1520
`define GOM_MARGIN_NS_SQUARE 5120
`define GOM_LAST_DOT 9'd511
`endif

/* hdl/gom_top.v */
`include "gom_consts.vh"

module gom_top #(
  parameter XW = 9,
  parameter YW = 8
) (
  // Clock and reset
  input wire CLK,
  input wire RESETN,
  // AXI4-Lite write address and data
  input wire [4:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // AXI4-Lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read
  input wire [4:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Raster timing from the terminal controller
  input wire HBLANK,
  input wire VBLANK,
  // Video
  output reg VIDEO,
  output reg VIDEO_WINDOW
);

  // ------------------------------------------------------------
  // Derived timing counts
  // ------------------------------------------------------------
  localparam DOT_RECT = `GOM_DOT_NS_RECT / `GOM_CLK_NS;
  localparam DOT_SQ = `GOM_DOT_NS_SQUARE / `GOM_CLK_NS;
  localparam MRG_RECT = (`GOM_MARGIN_NS_RECT + `GOM_CLK_NS - 1) / `GOM_CLK_NS;
  localparam MRG_SQ = (`GOM_MARGIN_NS_SQUARE + `GOM_CLK_NS - 1) / `GOM_CLK_NS;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [YW-1:0] curve0_mem [0:(1<<XW)-1]; // Graph 0 Y values
  reg [YW-1:0] curve1_mem [0:(1<<XW)-1]; // Graph 1 Y values
  reg [2:0] line_mem [0:(1<<XW)-1]; // Bit0 column rule, bit1/2 markers
  reg row_mem [0:(1<<YW)-1]; // Row rules, stored complemented

  // ------------------------------------------------------------
  // Decoder state and enable registers
  // ------------------------------------------------------------
  reg [6:0] cmd_r; // Last command letter
  reg first_r; // First data character held
  reg [4:0] low_r; // Low five bits of the word
  reg [4:0] r0a_r; // Register 0, first character
  reg [4:0] r0b_r; // Register 0, second character
  reg [4:0] r1a_r; // Register 1, first character
  reg [4:0] r1b_r; // Register 1, second character
  reg [YW-1:0] base0_r; // Baseline 0 position
  reg [YW-1:0] base1_r; // Baseline 1 position
  reg [XW-1:0] xinit_r; // Initial X-address counter
  reg strip_ff_r; // Strip-enable flip-flop
  reg [6:0] last_char_r; // Last character seen, for software

  // Character strobe from the CHAR register
  wire wr_take = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
  wire char_stb = wr_take & (S_AXI_AWADDR == `GOM_OFS_CHAR) & S_AXI_WSTRB[0];
  wire [6:0] ch = S_AXI_WDATA[6:0];
  wire is_cmd = char_stb & (ch[6:5] == `GOM_CLASS_CMD);
  wire is_data = char_stb & (ch[6:5] == `GOM_CLASS_DATA);
  wire second = is_data & first_r;
  wire [XW-1:0] word_x = {ch[3:0], low_r};
  wire [YW-1:0] word_y = {ch[2:0], low_r};
  wire wbit = ch[`GOM_WBIT];
  wire single_scroll_enable = r0b_r[`GOM_R0B_SINGLE];
  wire dual_scroll_enable = r0b_r[`GOM_R0B_DUAL];
  wire strip_mode = single_scroll_enable | dual_scroll_enable;
  wire strip_on = strip_mode & strip_ff_r;
  wire square = r1b_r[`GOM_R1B_SQUARE];

  // Load requests from the decoded letter on the completing character
  wire curve0_load_request = second & (cmd_r == `GOM_CMD_GRAPH0);
  wire curve1_load_request = second & (cmd_r == `GOM_CMD_GRAPH1);
  wire column_rule_load = second & (cmd_r == `GOM_CMD_VLINE);
  wire marker0_load = second & (cmd_r == `GOM_CMD_MARK0);
  wire marker1_load = second & (cmd_r == `GOM_CMD_MARK1);
  wire row_rule_mux_select = second & (cmd_r == `GOM_CMD_HLINE);
  // In dual mode graph 1 goes one step back so both graphs share X
  wire [XW-1:0] gx = (curve1_load_request & dual_scroll_enable) ?
                     xinit_r - {{(XW-1){1'b0}}, 1'b1} : xinit_r;

  // ------------------------------------------------------------
  // Character decoder and enable registers
  // ------------------------------------------------------------
  // Commands restart the two-character assembly; data alternates
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_r <= `GOM_CMD_NOP;
      first_r <= 1'b0;
      low_r <= `GOM_RST_REG5;
      r0a_r <= `GOM_RST_REG5;
      r0b_r <= `GOM_RST_REG5;
      r1a_r <= `GOM_RST_REG5;
      r1b_r <= `GOM_RST_REG5;
      base0_r <= {YW{1'b0}};
      base1_r <= {YW{1'b0}};
      last_char_r <= 7'h00;
    end else if (is_cmd) begin
      cmd_r <= ch;
      first_r <= 1'b0;
      last_char_r <= ch;
    end else if (is_data) begin
      last_char_r <= ch;
      first_r <= ~first_r;
      if (!first_r) begin
        // First character: held low bits, register first fields
        low_r <= ch[4:0];
        if (cmd_r == `GOM_CMD_REG0)
          r0a_r <= ch[4:0];
        if (cmd_r == `GOM_CMD_REG1)
          r1a_r <= ch[4:0];
      end else begin
        // Second character completes the word
        case (cmd_r)
          `GOM_CMD_REG0: r0b_r <= ch[4:0];
          `GOM_CMD_REG1: r1b_r <= ch[4:0];
          `GOM_CMD_NOP: begin
            if (r0b_r[`GOM_R0B_BASESEL])
              base1_r <= word_y;
            else
              base0_r <= word_y;
          end
          default: begin
            // Other letters act through the write strobes
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Initial X-address counter and strip-enable flip-flop
  // ------------------------------------------------------------
  // Graph, column-rule and marker writes step the counter, except graph 1 in dual mode; an X load sets it
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      xinit_r <= {XW{1'b0}};
      strip_ff_r <= 1'b0;
    end else begin
      if (second & (cmd_r == `GOM_CMD_XLOAD))
        xinit_r <= word_x;
      else if (curve0_load_request | column_rule_load | marker0_load |
               marker1_load | (curve1_load_request & ~dual_scroll_enable)) begin
        xinit_r <= xinit_r + {{(XW-1){1'b0}}, 1'b1};
        // Wrap from 511 is the overflow that arms scrolling
        if (&xinit_r)
          strip_ff_r <= 1'b1;
      end else if (!strip_mode)
        strip_ff_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Raster timing: blank edges, dot divider, margin, window
  // ------------------------------------------------------------
  reg hb_q_r; // HBLANK one cycle late, for edges
  reg [3:0] div_r; // Dot-rate divider
  reg [9:0] mrg_r; // Left margin countdown
  reg run_r; // Graph window open on this row
  reg [XW-1:0] dot_cnt_r; // Dot position in the window
  reg [XW-1:0] xfin_r; // Final X-address counter
  reg [YW-1:0] y_r; // Y-address monitor
  reg phase_r; // Alternate-dot phase, a 160 ns signal in the square field, 180 ns in the rectangular

  wire hb_rise = HBLANK & ~hb_q_r;
  // The rising edge of HBLANK steps the Y monitor; the level of either blank clears the window
  wire dot_en = (div_r == 4'd0);
  wire blank_time_clear = HBLANK | VBLANK;

  // Dot enable: one pulse per dot period, rate follows the field
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_r <= 4'd0;
      hb_q_r <= 1'b1; // Blank idles high: no false edge after reset
    end else begin
      hb_q_r <= HBLANK;
      if (dot_en)
        div_r <= square ? DOT_SQ[3:0] - 4'd1 : DOT_RECT[3:0] - 4'd1;
      else
        div_r <= div_r - 4'd1;
    end
  end

  // Y monitor: reload at bottom, step down once per row
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      y_r <= `GOM_Y_RECT;
    else if (VBLANK)
      y_r <= square ? `GOM_Y_SQUARE : `GOM_Y_RECT;
    else if (hb_rise && y_r != {YW{1'b0}})
      y_r <= y_r - {{(YW-1){1'b0}}, 1'b1};
  end

  // Margin then 512-dot window (511 in dual mode); final X steps per dot
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mrg_r <= 10'd0;
      run_r <= 1'b0;
      dot_cnt_r <= {XW{1'b0}};
      xfin_r <= {XW{1'b0}};
      phase_r <= 1'b0;
    end else if (blank_time_clear) begin
      run_r <= 1'b0;
      // Scrolling follows the initial counter, else restart at 0
      xfin_r <= strip_on ? xinit_r : {XW{1'b0}};
      // Dual mode starts one dot in to hide the switching column
      dot_cnt_r <= dual_scroll_enable ? {{(XW-1){1'b0}}, 1'b1} : {XW{1'b0}};
      mrg_r <= square ? MRG_SQ[9:0] : MRG_RECT[9:0];
      phase_r <= 1'b0;
    end else if (mrg_r != 10'd0) begin
      mrg_r <= mrg_r - 10'd1;
      run_r <= (mrg_r == 10'd1) && (y_r != {YW{1'b0}});
    end else if (run_r && dot_en) begin
      xfin_r <= xfin_r + {{(XW-1){1'b0}}, 1'b1};
      dot_cnt_r <= dot_cnt_r + {{(XW-1){1'b0}}, 1'b1};
      phase_r <= ~phase_r;
      if (dot_cnt_r == `GOM_LAST_DOT)
        run_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Memory writes and display reads
  // ------------------------------------------------------------
  reg [YW-1:0] g0_q_r; // Graph 0 value at this dot
  reg [YW-1:0] g1_q_r; // Graph 1 value at this dot
  reg [2:0] ln_q_r; // Latched line and marker bits
  reg row_q_r; // Row-rule word for this row (complemented)
  reg shown_r; // Read stage holds a displayed dot
  reg ph_q_r; // Phase aligned with the read stage
  wire dot_read = run_r & dot_en & (mrg_r == 10'd0) & ~blank_time_clear;

  // Graph memories: host writes at X, display reads at final X
  always @(posedge CLK) begin
    if (curve0_load_request)
      curve0_mem[gx] <= word_y;
    if (curve1_load_request)
      curve1_mem[gx] <= word_y;
    if (dot_read) begin
      g0_q_r <= curve0_mem[xfin_r];
      g1_q_r <= curve1_mem[xfin_r];
    end
  end

  // Line and marker memory: host write wins, else read-back rewrite
  always @(posedge CLK) begin
    if (column_rule_load)
      line_mem[word_x][0] <= wbit;
    else if (marker0_load)
      line_mem[word_x][1] <= wbit;
    else if (marker1_load)
      line_mem[word_x][2] <= wbit;
    else if (dot_read)
      line_mem[xfin_r] <= line_mem[xfin_r];
    if (dot_read)
      ln_q_r <= line_mem[xfin_r];
  end

  // Row-rule memory: addressed by Y position on load, by Y monitor on read
  always @(posedge CLK) begin
    if (row_rule_mux_select)
      row_mem[word_y] <= ~wbit;
    row_q_r <= row_mem[y_r];
  end

  // Read stage valid flag
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      shown_r <= 1'b0;
      ph_q_r <= 1'b0;
    end else begin
      if (dot_read)
        ph_q_r <= phase_r;
      if (blank_time_clear)
        shown_r <= 1'b0;
      else if (dot_read)
        shown_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Comparators and video combining
  // ------------------------------------------------------------
  wire en_all = r0a_r[`GOM_R0A_DISPLAY];
  wire g0_hit = r0a_r[`GOM_R0A_GRAPH0] & (g0_q_r == y_r);
  wire g1_hit = r0a_r[`GOM_R0A_GRAPH1] & (g1_q_r == y_r);
  wire b0_on = r0b_r[`GOM_R0B_BASE0];
  wire b1_on = r0b_r[`GOM_R0B_BASE1];
  wire base_hit = (b0_on & (base0_r == y_r)) | (b1_on & (base1_r == y_r));
  // Fill to the field bottom when the fill bit is set; an enabled baseline adds the band up to it
  wire h0_fill = r0a_r[`GOM_R0A_HIST0] & (y_r < g0_q_r);
  wire h1_fill = r0a_r[`GOM_R0A_HIST1] & (y_r < g1_q_r);
  wire s0_band = b0_on & (((y_r <= g0_q_r) & (y_r >= base0_r)) |
                          ((y_r >= g0_q_r) & (y_r <= base0_r)));
  wire s1_band = b1_on & (((y_r <= g1_q_r) & (y_r >= base1_r)) |
                          ((y_r >= g1_q_r) & (y_r <= base1_r)));
  // Alternate the two shadings so overlaps stay distinguishable
  wire shade = ph_q_r ? (h1_fill | s1_band) : (h0_fill | s0_band);
  // Markers match on the upper nibble only: a 16-line segment
  wire m0_hit = r1a_r[`GOM_R1A_MARK0] & ln_q_r[1] & (g0_q_r[7:4] == y_r[7:4]);
  wire m1_hit = r1a_r[`GOM_R1A_MARK1] & ln_q_r[2] & (g1_q_r[7:4] == y_r[7:4]);
  wire column_rule_video = r1a_r[`GOM_R1A_VLINE] & ln_q_r[0] & y_r[0];
  wire row_rule_enable = r1a_r[`GOM_R1A_HLINE];
  wire row_video = row_rule_enable & ~row_q_r & ph_q_r;
  wire dot_on = g0_hit | g1_hit | base_hit | shade | m0_hit | m1_hit |
                column_rule_video | row_video;

  // Video is registered so the output never glitches
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      VIDEO <= 1'b0;
      VIDEO_WINDOW <= 1'b0;
    end else begin
      VIDEO <= en_all & shown_r & dot_on;
      VIDEO_WINDOW <= shown_r;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  // Address and data are taken together; the response follows
  wire wr_map = (S_AXI_AWADDR == `GOM_OFS_CHAR);
  assign S_AXI_AWREADY = wr_take;
  assign S_AXI_WREADY = wr_take;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // Write response channel
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `GOM_RESP_OKAY;
    end else if (wr_take) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_map ? `GOM_RESP_OKAY : `GOM_RESP_SLVERR;
    end else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // Read data channel: block state visible to software
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `GOM_RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `GOM_RESP_OKAY;
      case (S_AXI_ARADDR)
        `GOM_OFS_CHAR: S_AXI_RDATA <= {24'h000000, first_r, last_char_r};
        `GOM_OFS_ENABLES: S_AXI_RDATA <= {12'h000, r1b_r, r1a_r, r0b_r, r0a_r};
        `GOM_OFS_XADDR: S_AXI_RDATA <= {7'h00, xfin_r, 7'h00, xinit_r};
        `GOM_OFS_BASE: S_AXI_RDATA <= {16'h0000, base1_r, base0_r};
        `GOM_OFS_STATUS: S_AXI_RDATA <= {22'h000000, strip_on, strip_ff_r, y_r};
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `GOM_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

endmodule // gom_top

/* verification/gom_term.sv */
// ------------------------------------------------------------
// Raster timing of the terminal controller
// ------------------------------------------------------------
module gom_term #(
  parameter int ROW_CLKS = 4900,
  parameter int BLANK_CLKS = 100,
  parameter int ROWS = 5
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Frame request from the bench
  input logic run,
  // Blanking towards the block
  output logic hblank,
  output logic vblank
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r; // Clock within the row
  int row_r; // Row zero is the vertical blank row
  // Position stands at the top of the frame while idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || !run) begin
      cnt_r <= 0;
      row_r <= 0;
    end else if (cnt_r == ROW_CLKS - 1) begin
      cnt_r <= 0;
      row_r <= (row_r == ROWS - 1) ? 0 : row_r + 1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // Idle keeps both blanks high, so the Y monitor sits at its reload value
  assign hblank = !run || row_r == 0 || cnt_r < BLANK_CLKS;
  assign vblank = !run || row_r == 0;
endmodule // gom_term

/* verification/gom_top_asserts.sv */
`include "gom_consts.vh"
// ------------------------------------------------------------
// Port checker for the graph overlay block
// ------------------------------------------------------------
module gom_chk (
  // Clock and reset
  input logic CLK,
  input logic RESETN,
  // Register bus
  input logic [4:0] S_AXI_AWADDR,
  input logic S_AXI_AWVALID,
  input logic S_AXI_WVALID,
  input logic [1:0] S_AXI_BRESP,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [4:0] S_AXI_ARADDR,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic [1:0] S_AXI_RRESP,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  // Raster and video
  input logic HBLANK,
  input logic VIDEO,
  input logic VIDEO_WINDOW
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain; every check is quiet while reset is low
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Write answer comes exactly one cycle after the take
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
    |=> S_AXI_BVALID) else $error("write answer late");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  // Offsets above the status word hold nothing
  a_bad_write: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
    && S_AXI_AWADDR > 5'h10 |=> S_AXI_BRESP == `GOM_RESP_SLVERR) else $error("bad write ok");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
  a_bad_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 5'h10
    |=> S_AXI_RRESP == `GOM_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("bad read ok");
  // Nothing is shown once blank has settled, nor in the first 8 clocks of the left margin
  a_blank_dark: assert property (HBLANK [*8] |-> !VIDEO && !VIDEO_WINDOW)
    else $error("video during blank");
  a_margin_dark: assert property ($fell(HBLANK) |-> !VIDEO_WINDOW [*8])
    else $error("window in margin");
endmodule // gom_chk

bind gom_top gom_chk u_chk (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .HBLANK(HBLANK), .VIDEO(VIDEO), .VIDEO_WINDOW(VIDEO_WINDOW));

/* verification/graph_overlay_memory_display_tb.sv */
`include "gom_consts.vh"
// ------------------------------------------------------------
// Self-checking bench for the graph overlay block
// ------------------------------------------------------------
module graph_overlay_memory_display_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 80000; // The tests need about 52000 cycles
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic run = 1'h0; // Partner sends frames while high
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] vcnt = 16'h0; // Lit clocks of the current row
  logic prev_hb = 1'h1, prev_vb = 1'h1;
  logic [7:0] b0, b1;
  wire awready, wready, bvalid, arready, rvalid, hblank, vblank, video, vwin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int num_errors = 0, comparisons = 0, cycles = 0;
  logic [1:0] bq[$]; // Expected write answers, oldest first
  logic [33:0] rq[$]; // Expected {response, data} of reads
  logic rowq[$]; // Expected lit flag of each visible row
  gom_top u_dut (
    .CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HBLANK(hblank), .VBLANK(vblank), .VIDEO(video), .VIDEO_WINDOW(vwin));
  gom_term u_term (.clk(clk), .rst_n(rst_n), .run(run), .hblank(hblank), .vblank(vblank));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // An empty queue turns any result into a mismatch
  task automatic cmp_resp(input logic [1:0] got);
    chk({32'h0, got}, {32'h0, bq.size() ? bq.pop_front() : ~got});
  endtask
  task automatic cmp_read(input logic [33:0] got);
    chk(got, rq.size() ? rq.pop_front() : ~got);
  endtask
  task automatic cmp_row(input logic got);
    chk({33'h0, got}, {33'h0, rowq.size() ? rowq.pop_front() : ~got});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Write: address and data together; bready stands until bvalid is sampled
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = `GOM_RESP_OKAY);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bq.push_back(r);
    do @(posedge clk); while (!(awready === 1'h1 && wready === 1'h1));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  // Read: rready stands until rvalid is sampled, data taken at that edge
  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = `GOM_RESP_OKAY);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    rq.push_back({r, d});
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask
  task automatic chr(input logic [6:0] c);
    wr(`GOM_OFS_CHAR, {25'h0, c});
  endtask
  // Two data characters: low five bits, then the upper bits with write bit clear
  task automatic pair(input logic [8:0] v);
    chr({2'h1, v[4:0]});
    chr({3'h2, v[8:5]});
  endtask
  // Results are matched to the oldest expectation of their kind
  always @(posedge clk) begin
    if (bvalid && bready) cmp_resp(bresp);
    if (rvalid && rready) cmp_read({rresp, rdata});
    if (hblank && !prev_hb && !prev_vb) cmp_row(vcnt != 16'h0);
    vcnt <= hblank ? 16'h0 : vcnt + {15'h0, video};
    prev_hb <= hblank;
    prev_vb <= vblank;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h47EE));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(`GOM_OFS_ENABLES, 32'h0);
    rd(`GOM_OFS_STATUS, 32'h000000E6);
    $display("test reset_state done");
    // Every graph 0 cell is written, so no unknown cell reaches the video
    chr(`GOM_CMD_XLOAD);
    pair(9'h000);
    chr(`GOM_CMD_GRAPH0);
    for (int i = 0; i < 512; i++) pair(i == 0 ? 9'h0E5 : 9'h000);
    rd(`GOM_OFS_XADDR, 32'h0);
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    // Rows carry Y 230 down to 227; only 229 holds the dot
    for (int i = 0; i < 4; i++) rowq.push_back(i == 1);
    run <= 1'h1;
    while (rowq.size() != 0) @(posedge clk);
    run <= 1'h0;
    $display("test graph_dot done");
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    chr(7'h28);
    chr(`GOM_CMD_REG1);
    chr(7'h20);
    chr(7'h21);
    rd(`GOM_OFS_ENABLES, 32'h00008103);
    rd(`GOM_OFS_STATUS, 32'h000000F0);
    chr(`GOM_CMD_XLOAD);
    pair(9'h1FF);
    rd(`GOM_OFS_XADDR, 32'h000001FF);
    chr(`GOM_CMD_GRAPH0);
    pair(9'h000);
    rd(`GOM_OFS_STATUS, 32'h000003F0);
    chr(`GOM_CMD_XLOAD);
    pair(9'h005);
    rd(`GOM_OFS_XADDR, 32'h00050005);
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    chr(7'h20);
    rd(`GOM_OFS_XADDR, 32'h00000005);
    // Dual mode: B steps the X counter, J writes one step back and holds it
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    chr(7'h30);
    chr(`GOM_CMD_XLOAD);
    pair(9'h010);
    chr(`GOM_CMD_GRAPH0);
    pair(9'h000);
    chr(`GOM_CMD_GRAPH1);
    pair(9'h000);
    rd(`GOM_OFS_XADDR, 32'h00000011);
    // Line and marker writes step the X counter as graph writes do
    chr(`GOM_CMD_VLINE);
    pair(9'h000);
    chr(`GOM_CMD_MARK0);
    pair(9'h000);
    chr(`GOM_CMD_MARK1);
    pair(9'h000);
    rd(`GOM_OFS_XADDR, 32'h00000014);
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    chr(7'h20);
    $display("test strip_chart done");
    // Fill bits stay clear while baselines are loaded
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    chr(`GOM_CMD_NOP);
    pair({1'h0, b0});
    chr(`GOM_CMD_REG0);
    chr(7'h23);
    chr(7'h21);
    chr(`GOM_CMD_NOP);
    pair({1'h0, b1});
    rd(`GOM_OFS_BASE, {16'h0, b1, b0});
    $display("test baselines done");
    // Square field rows carry Y 240 down to 237; only 239 holds a row rule
    chr(`GOM_CMD_REG1);
    chr(7'h21);
    chr(`GOM_CMD_HLINE);
    for (int i = 237; i < 241; i++) begin
      chr({2'h1, i[4:0]});
      chr({2'h1, i == 239, 1'h0, i[7:5]});
    end
    for (int i = 0; i < 4; i++) rowq.push_back(i == 1);
    run <= 1'h1;
    while (rowq.size() != 0) @(posedge clk);
    run <= 1'h0;
    $display("test row_rule done");
    wr(5'h18, 32'h00000041, `GOM_RESP_SLVERR);
    rd(5'h14, 32'h0, `GOM_RESP_SLVERR);
    $display("test unmapped done");
    print_verdict();
  end
endmodule // graph_overlay_memory_display_tb
